/* File: design/ulp_i2c_slave.sv */
/*
  Byte-wide I2C register slave: device address, register pointer, then
  auto-incrementing writes or reads.
  Assumes scl and sda are already synchronous to mclk.
*/
`default_nettype none

module ulp_i2c_slave (
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              enable,
  input  wire logic [6:0]        dev_addr,
  input  wire logic              scl,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  output ulp_pkg::ulp_reg_wr_s   reg_wr,
  output logic [7:0]             rd_addr,
  input  wire logic [7:0]        rd_data
);

  typedef struct packed {
    ulp_pkg::ulp_i2c_e st;
    logic [7:0]        sh;
    logic [3:0]        cnt;
    logic [7:0]        ptr;
    logic              rw;
    logic              nack;
    logic              oe;
    logic              scl_q;
    logic              sda_q;
    ulp_pkg::ulp_reg_wr_s wr;
  } ulp_i2c_s;

  ulp_i2c_s st_reg;
  ulp_i2c_s st_next;
  logic     scl_rise;
  logic     scl_fall;

  assign scl_rise = scl & ~st_reg.scl_q;
  assign scl_fall = ~scl & st_reg.scl_q;

  always_comb begin
    st_next        = st_reg;
    st_next.scl_q  = scl;
    st_next.sda_q  = sda_in;
    st_next.wr.stb = 1'b0;
    if (!enable) begin
      st_next.st = ulp_pkg::I2C_IDLE;
      st_next.oe = 1'b0;
    end else if (scl && st_reg.scl_q && st_reg.sda_q && !sda_in) begin
      // Start or repeated start
      st_next.st  = ulp_pkg::I2C_DEV;
      st_next.cnt = 4'h0;
      st_next.oe  = 1'b0;
    end else if (scl && st_reg.scl_q && !st_reg.sda_q && sda_in) begin
      st_next.st = ulp_pkg::I2C_IDLE;
      st_next.oe = 1'b0;
    end else if (scl_rise) begin
      case (st_reg.st)
        ulp_pkg::I2C_DEV, ulp_pkg::I2C_PTR, ulp_pkg::I2C_WR: begin
          st_next.sh  = {st_reg.sh[6:0], sda_in};
          st_next.cnt = st_reg.cnt + 4'h1;
        end
        ulp_pkg::I2C_RACK: st_next.nack = sda_in;
        default: st_next.sh = st_reg.sh;
      endcase
    end else if (scl_fall) begin
      case (st_reg.st)
        ulp_pkg::I2C_DEV: begin
          if (st_reg.cnt == 4'h8) begin
            if (st_reg.sh[7:1] == dev_addr) begin
              st_next.st = ulp_pkg::I2C_DACK;
              st_next.oe = 1'b1;
              st_next.rw = st_reg.sh[0];
            end else begin
              st_next.st = ulp_pkg::I2C_IDLE;
            end
          end
        end
        ulp_pkg::I2C_DACK: begin
          st_next.oe  = 1'b0;
          st_next.cnt = 4'h0;
          st_next.st  = ulp_pkg::I2C_PTR;
          if (st_reg.rw) begin
            st_next.sh  = rd_data;
            st_next.oe  = ~rd_data[7];
            st_next.cnt = 4'h1;
            st_next.st  = ulp_pkg::I2C_RD;
          end
        end
        ulp_pkg::I2C_PTR: begin
          if (st_reg.cnt == 4'h8) begin
            st_next.ptr = st_reg.sh;
            st_next.oe  = 1'b1;
            st_next.st  = ulp_pkg::I2C_PACK;
          end
        end
        ulp_pkg::I2C_WR: begin
          if (st_reg.cnt == 4'h8) begin
            st_next.wr.stb  = 1'b1;
            st_next.wr.addr = st_reg.ptr;
            st_next.wr.data = st_reg.sh;
            st_next.oe      = 1'b1;
            st_next.st      = ulp_pkg::I2C_WACK;
          end
        end
        ulp_pkg::I2C_PACK, ulp_pkg::I2C_WACK: begin
          st_next.oe  = 1'b0;
          st_next.cnt = 4'h0;
          st_next.st  = ulp_pkg::I2C_WR;
          if (st_reg.st == ulp_pkg::I2C_WACK) begin
            st_next.ptr = st_reg.ptr + 8'h01;
          end
        end
        ulp_pkg::I2C_RD: begin
          if (st_reg.cnt == 4'h8) begin
            st_next.oe  = 1'b0;
            st_next.ptr = st_reg.ptr + 8'h01;
            st_next.st  = ulp_pkg::I2C_RACK;
          end else begin
            st_next.oe  = ~st_reg.sh[6];
            st_next.sh  = {st_reg.sh[6:0], 1'b0};
            st_next.cnt = st_reg.cnt + 4'h1;
          end
        end
        ulp_pkg::I2C_RACK: begin
          if (!st_reg.nack) begin
            st_next.sh  = rd_data;
            st_next.oe  = ~rd_data[7];
            st_next.cnt = 4'h1;
            st_next.st  = ulp_pkg::I2C_RD;
          end else begin
            st_next.st = ulp_pkg::I2C_IDLE;
          end
        end
        default: st_next.st = ulp_pkg::I2C_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg       <= '0;
      st_reg.st    <= ulp_pkg::I2C_IDLE;
      st_reg.scl_q <= 1'b1;
      st_reg.sda_q <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = st_reg.oe;
  assign reg_wr  = st_reg.wr;
  assign rd_addr = st_reg.ptr;

endmodule

`default_nettype wire

/* File: design/ulp_link_ctrl.sv */
/*
  USB link power and loss-of-signal control: strap sampling, register file
  reached over I2C, compliance control, LFPS equalization and debounce,
  periodic receiver detection and loss-of-signal settings.
  Assumes all pins are synchronous to mclk; strap levels are 2-bit codes
  (0 low, 1 resistor, 2 float, 3 high).
*/
`default_nettype none

module ulp_link_ctrl #(
  parameter int LFPS_DEBOUNCE_CYC = ulp_pkg::LFPS_DEBOUNCE_CYC,
  parameter int RXDET_SHORT_CYC   = ulp_pkg::RXDET_SHORT_CYC,
  parameter int RXDET_LONG_CYC    = ulp_pkg::RXDET_LONG_CYC
) (
  input  wire logic                                  mclk,
  input  wire logic                                  srst,
  input  wire logic                                  scl,
  input  wire logic                                  sda_in,
  output logic                                       sda_out,
  output logic                                       sda_oe,
  input  wire logic [1:0]                            i2c_mode_strap,
  input  wire logic [1:0]                            addr_strap_hi,
  input  wire logic [1:0]                            addr_strap_lo,
  input  wire logic [3:0]                            downstream_eq_straps,
  input  wire logic                                  config_select_hi,
  input  wire logic                                  config_select_lo,
  input  wire ulp_pkg::ulp_link_in_s                 link_in,
  output ulp_pkg::ulp_link_out_s                     link_out,
  output logic [ulp_pkg::NUM_EQ_CH-1:0][3:0]         eq_out,
  output logic                                       i2c_mode,
  output logic                                       usb_only_mode,
  output logic [2:0]                                 signal_loss_threshold,
  output logic [2:0]                                 signal_loss_hysteresis
);

  typedef struct packed {
    logic                                 strap_done;
    logic                                 i2c_en;
    logic [6:0]                           dev_addr;
    logic [3:0]                           ustrap;
    logic [3:0]                           dstrap;
    logic [7:0]                           gen_ctrl;
    logic [3:0][7:0]                      eq_regs;
    logic [7:0]                           usb_link_power_ctrl;
    logic [7:0]                           signal_loss_cfg;
    logic [ulp_pkg::CNT_W-1:0]            dbnc_cnt;
    logic [ulp_pkg::CNT_W-1:0]            per_cnt;
    ulp_pkg::ulp_link_out_s               lo;
    logic [ulp_pkg::NUM_EQ_CH-1:0][3:0]   eq;
    logic                                 usb_only;
  } ulp_state_s;

  ulp_state_s                          st_reg;
  ulp_state_s                          st_next;
  ulp_pkg::ulp_reg_wr_s                reg_wr;
  logic [7:0]                          rd_addr;
  logic [7:0]                          rd_data;
  logic [ulp_pkg::NUM_EQ_CH-1:0][3:0]  eq_eff;
  logic                                eq_ovr;

  assign eq_ovr = st_reg.gen_ctrl[ulp_pkg::BIT_EQ_OVR];

  ulp_i2c_slave u_i2c (
    .mclk     (mclk),
    .srst     (srst),
    .enable   (st_reg.i2c_en),
    .dev_addr (st_reg.dev_addr),
    .scl      (scl),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .reg_wr   (reg_wr),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );

  // ==========================================================================
  // Effective equalization per channel: 0-3 upstream, 4-7 downstream
  for (genvar i = 0; i < ulp_pkg::NUM_EQ_CH; i++) begin : g_eq
    localparam int REG = i / 2;
    localparam int NIB = i % 2;
    assign eq_eff[i] = (eq_ovr && st_reg.i2c_en) ? st_reg.eq_regs[REG][NIB*4 +: 4]
                     : ((i < 4) ? st_reg.ustrap : st_reg.dstrap);
  end

  // ==========================================================================
  // Register read path
  always_comb begin
    rd_data = 8'h00;
    if (rd_addr == ulp_pkg::OFS_GEN_CTRL) begin
      rd_data = st_reg.gen_ctrl;
    end else if (rd_addr == ulp_pkg::OFS_UEQ_2) begin
      rd_data = {eq_eff[1], eq_eff[0]};
    end else if (rd_addr == ulp_pkg::OFS_UEQ_1) begin
      rd_data = {eq_eff[3], eq_eff[2]};
    end else if (rd_addr == ulp_pkg::OFS_DEQ_2) begin
      rd_data = {eq_eff[5], eq_eff[4]};
    end else if (rd_addr == ulp_pkg::OFS_DEQ_1) begin
      rd_data = {eq_eff[7], eq_eff[6]};
    end else if (rd_addr == ulp_pkg::OFS_LINK_PWR) begin
      rd_data = st_reg.usb_link_power_ctrl;
    end else if (rd_addr == ulp_pkg::OFS_LOS) begin
      rd_data = st_reg.signal_loss_cfg & ulp_pkg::LOS_RW_MASK;
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    logic [1:0]                comp_dir;
    logic [1:0]                per_sel;
    logic                      cm_hw;
    logic                      exit_cond;
    logic [ulp_pkg::CNT_W-1:0] dbnc_tgt;
    logic [ulp_pkg::CNT_W-1:0] per_tgt;
    comp_dir  = 2'h0;
    per_sel   = 2'h0;
    cm_hw     = 1'b0;
    exit_cond = 1'b0;
    dbnc_tgt  = '0;
    per_tgt   = '0;
    st_next   = st_reg;
    st_next.lo.low_power_exit  = 1'b0;
    st_next.lo.rx_detect_pulse = 1'b0;

    // Straps are caught on the first edge after reset release
    if (!st_reg.strap_done) begin
      st_next.strap_done = 1'b1;
      st_next.i2c_en     = (i2c_mode_strap != ulp_pkg::LVL_LOW);
      st_next.dev_addr   = ulp_pkg::I2C_ADDR_BASE + {3'h0, addr_strap_hi, addr_strap_lo};
      st_next.ustrap     = {addr_strap_hi, addr_strap_lo};
      st_next.dstrap     = downstream_eq_straps;
    end

    // Register writes
    if (reg_wr.stb) begin
      if (reg_wr.addr == ulp_pkg::OFS_GEN_CTRL) begin
        st_next.gen_ctrl = reg_wr.data & ulp_pkg::GEN_RW_MASK;
      end else if (reg_wr.addr == ulp_pkg::OFS_UEQ_2 && eq_ovr) begin
        st_next.eq_regs[0] = reg_wr.data;
      end else if (reg_wr.addr == ulp_pkg::OFS_UEQ_1 && eq_ovr) begin
        st_next.eq_regs[1] = reg_wr.data;
      end else if (reg_wr.addr == ulp_pkg::OFS_DEQ_2 && eq_ovr) begin
        st_next.eq_regs[2] = reg_wr.data;
      end else if (reg_wr.addr == ulp_pkg::OFS_DEQ_1 && eq_ovr) begin
        st_next.eq_regs[3] = reg_wr.data;
      end else if (reg_wr.addr == ulp_pkg::OFS_LINK_PWR) begin
        st_next.usb_link_power_ctrl = reg_wr.data;
      end else if (reg_wr.addr == ulp_pkg::OFS_LOS) begin
        st_next.signal_loss_cfg = reg_wr.data & ulp_pkg::LOS_RW_MASK;
      end
    end

    // Compliance direction and hardware-owned flag
    comp_dir = st_reg.usb_link_power_ctrl[ulp_pkg::POS_COMP_DIR +: 2];
    case (comp_dir)
      ulp_pkg::COMP_FSM: cm_hw = link_in.fsm_compliance;
      ulp_pkg::COMP_DFP: cm_hw = 1'b1;
      ulp_pkg::COMP_UFP: cm_hw = 1'b1;
      default:           cm_hw = 1'b0;
    endcase
    st_next.lo.compliance_dfp = (comp_dir == ulp_pkg::COMP_DFP) ||
                                (comp_dir == ulp_pkg::COMP_FSM && link_in.fsm_compliance);
    st_next.lo.compliance_ufp = (comp_dir == ulp_pkg::COMP_UFP);
    st_next.lo.compliance_active_flag = cm_hw;
    // A write lands for one cycle, hardware takes the bit back on the next
    if (!(reg_wr.stb && reg_wr.addr == ulp_pkg::OFS_LINK_PWR)) begin
      st_next.usb_link_power_ctrl[ulp_pkg::BIT_COMPLIANCE_ACTIVE_FLAG] = cm_hw;
    end

    // LFPS debounce before leaving U2/U3
    exit_cond = link_in.in_u2u3 && link_in.lfps_present;
    dbnc_tgt  = st_reg.usb_link_power_ctrl[ulp_pkg::BIT_DEBOUNCE] ?
                ulp_pkg::CNT_W'(LFPS_DEBOUNCE_CYC) : ulp_pkg::CNT_W'(1);
    if (!exit_cond) begin
      st_next.dbnc_cnt = '0;
    end else if (st_reg.dbnc_cnt < dbnc_tgt) begin
      st_next.dbnc_cnt = st_reg.dbnc_cnt + ulp_pkg::CNT_W'(1);
      st_next.lo.low_power_exit = (st_reg.dbnc_cnt + ulp_pkg::CNT_W'(1) == dbnc_tgt);
    end

    // Periodic receiver detection on the downstream pairs
    per_sel = st_reg.usb_link_power_ctrl[ulp_pkg::POS_RXDET_PER +: 2];
    per_tgt = (per_sel == ulp_pkg::RXDET_PER_8MS) ? ulp_pkg::CNT_W'(RXDET_SHORT_CYC)
                                                  : ulp_pkg::CNT_W'(RXDET_LONG_CYC);
    if (st_reg.per_cnt + ulp_pkg::CNT_W'(1) >= per_tgt) begin
      st_next.per_cnt = '0;
      st_next.lo.rx_detect_pulse = !(link_in.in_u2u3 &&
                                     st_reg.usb_link_power_ctrl[ulp_pkg::BIT_RXDET_OFF]);
    end else begin
      st_next.per_cnt = st_reg.per_cnt + ulp_pkg::CNT_W'(1);
    end

    // Equalization applied to the receivers
    for (int i = 0; i < ulp_pkg::NUM_EQ_CH; i++) begin
      st_next.eq[i] = (link_in.lfps_present &&
                       !st_reg.usb_link_power_ctrl[ulp_pkg::BIT_APPLY_A]) ? 4'h0 : eq_eff[i];
    end

    st_next.usb_only = !config_select_hi && config_select_lo;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg                     <= '0;
      st_reg.gen_ctrl            <= ulp_pkg::RST_REG;
      st_reg.usb_link_power_ctrl <= ulp_pkg::RST_REG;
      st_reg.signal_loss_cfg     <= ulp_pkg::RST_REG;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link_out               = st_reg.lo;
  assign eq_out                 = st_reg.eq;
  assign i2c_mode               = st_reg.i2c_en;
  assign usb_only_mode          = st_reg.usb_only;
  assign signal_loss_threshold  = st_reg.signal_loss_cfg[ulp_pkg::POS_LOS_VTH +: 3];
  assign signal_loss_hysteresis = st_reg.signal_loss_cfg[ulp_pkg::POS_LOS_HYST +: 3];

endmodule

`default_nettype wire

/* File: design/ulp_pkg.sv */
/*
  Shared constants, field layouts and carrier types for the USB link power
  and loss-of-signal control block.
  Assumes a single 40 MHz clock and a synchronous active-high reset.
*/
`default_nettype none

package ulp_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_KHZ           = 40000;
  localparam int LFPS_DEBOUNCE_US  = 200;
  localparam int LFPS_DEBOUNCE_CYC = (LFPS_DEBOUNCE_US * CLK_KHZ + 999) / 1000;
  localparam int RXDET_SHORT_MS    = 8;
  localparam int RXDET_LONG_MS     = 12;
  localparam int RXDET_SHORT_CYC   = RXDET_SHORT_MS * CLK_KHZ;
  localparam int RXDET_LONG_CYC    = RXDET_LONG_MS * CLK_KHZ;
  localparam int CNT_W             = 20;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_GEN_CTRL = 8'h0a;
  localparam logic [7:0] OFS_UEQ_2    = 8'h10;
  localparam logic [7:0] OFS_UEQ_1    = 8'h11;
  localparam logic [7:0] OFS_DEQ_2    = 8'h20;
  localparam logic [7:0] OFS_DEQ_1    = 8'h21;
  localparam logic [7:0] OFS_LINK_PWR = 8'h22;
  localparam logic [7:0] OFS_LOS      = 8'h23;

  // ==========================================================================
  // Field positions and reset values
  localparam int BIT_COMPLIANCE_ACTIVE_FLAG  = 7;
  localparam int BIT_APPLY_A    = 6;
  localparam int BIT_DEBOUNCE   = 5;
  localparam int BIT_RXDET_OFF  = 4;
  localparam int POS_RXDET_PER  = 2;
  localparam int POS_COMP_DIR   = 0;
  localparam int POS_LOS_HYST   = 3;
  localparam int POS_LOS_VTH    = 0;
  localparam int BIT_EQ_OVR     = 4;
  localparam logic [7:0] LOS_RW_MASK = 8'h3f;
  localparam logic [7:0] GEN_RW_MASK = 8'h10;
  localparam logic [7:0] RST_REG     = 8'h00;

  // ==========================================================================
  // Codes
  localparam logic [1:0] COMP_FSM      = 2'h0;
  localparam logic [1:0] COMP_DFP      = 2'h1;
  localparam logic [1:0] COMP_UFP      = 2'h2;
  localparam logic [1:0] RXDET_PER_8MS = 2'h0;
  localparam logic [1:0] LVL_LOW       = 2'h0;
  localparam logic [6:0] I2C_ADDR_BASE = 7'h08;
  localparam int NUM_EQ_CH = 8;

  typedef logic [3:0] ulp_eq_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic lfps_present;
    logic in_u2u3;
    logic fsm_compliance;
  } ulp_link_in_s;

  typedef struct packed {
    logic compliance_active_flag;
    logic compliance_dfp;
    logic compliance_ufp;
    logic low_power_exit;
    logic rx_detect_pulse;
  } ulp_link_out_s;

  typedef struct packed {
    logic       stb;
    logic [7:0] addr;
    logic [7:0] data;
  } ulp_reg_wr_s;

  typedef enum logic [3:0] {
    I2C_IDLE, I2C_DEV, I2C_DACK, I2C_PTR, I2C_PACK, I2C_WR, I2C_WACK, I2C_RD, I2C_RACK
  } ulp_i2c_e;

endpackage

`default_nettype wire

/* File: verification/testbench.sv */
/*
  Self-checking testbench for ulp_link_ctrl through its I2C registers.
  Assumes shortened count parameters; address straps float until the strap address test drives them high and low.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DEB = 20;
  localparam int SHORT = 50;
  localparam int LONG = 80;
  logic                               mclk;
  logic                               srst;
  logic                               scl;
  logic                               sda_drv;
  logic                               sda_oe;
  logic                               sda_out;
  wire logic                          sda_line;
  logic [1:0]                         mode_strap;
  logic [3:0]                         deq;
  logic [3:0]                         astr;
  logic                               cfg_hi;
  logic                               cfg_lo;
  ulp_pkg::ulp_link_in_s              lin;
  ulp_pkg::ulp_link_out_s             lout;
  logic [ulp_pkg::NUM_EQ_CH-1:0][3:0] eq;
  logic                               i2c_mode;
  logic                               usb_only;
  logic [2:0]                         vth;
  logic [2:0]                         hyst;
  logic [6:0]                         dev;
  logic                               ack;
  logic [7:0]                         rb;
  int                                 n;
  int                                 num_errors = 0;
  int                                 total_checks = 0;
  assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
  ulp_link_ctrl #(.LFPS_DEBOUNCE_CYC(DEB), .RXDET_SHORT_CYC(SHORT), .RXDET_LONG_CYC(LONG)) i_ulp_link_ctrl (
    .mclk(mclk), .srst(srst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .i2c_mode_strap(mode_strap), .addr_strap_hi(astr[3:2]), .addr_strap_lo(astr[1:0]),
    .downstream_eq_straps(deq), .config_select_hi(cfg_hi), .config_select_lo(cfg_lo), .link_in(lin),
    .link_out(lout), .eq_out(eq), .i2c_mode(i2c_mode), .usb_only_mode(usb_only),
    .signal_loss_threshold(vth), .signal_loss_hysteresis(hyst));
  ulp_i2c_master u_master (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // =====
  // Helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic do_reset();
    srst = 1'b1;
    step(6);
    srst = 1'b0;
    step(3);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic k;
    u_master.start();
    u_master.xfer({dev, 1'b0}, 1'b1, r, ack);
    if (ack === 1'b1) begin
      u_master.xfer(a, 1'b1, r, k);
      u_master.xfer(d, 1'b1, r, k);
    end
    u_master.stop();
  endtask
  task automatic rd(input logic [7:0] a);
    logic k;
    u_master.start();
    u_master.xfer({dev, 1'b0}, 1'b1, rb, k);
    u_master.xfer(a, 1'b1, rb, k);
    u_master.start();
    u_master.xfer({dev, 1'b1}, 1'b1, rb, k);
    u_master.xfer(8'hff, 1'b1, rb, k);
    u_master.stop();
  endtask
  task automatic cycles_to(input logic rxdet);
    n = 0;
    while (n < 200 && (rxdet ? lout.rx_detect_pulse : lout.low_power_exit) !== 1'b1) begin
      step(1);
      n++;
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    test_done();
  end
  // =====
  // Tests
  initial begin
    srst = 1'b1;
    mode_strap = 2'h3;
    deq = 4'h5;
    astr = 4'ha;
    cfg_hi = 1'b0;
    cfg_lo = 1'b1;
    lin = '0;
    dev = 7'h12;
    do_reset();
    chk("i2c_mode", i2c_mode, 1'b1);
    for (int k = 0; k < 4; k++) begin
      {cfg_hi, cfg_lo} = 2'(k);
      step(2);
      chk("usb_only", usb_only, k == 1);
    end
    chk("los fields", {hyst, vth}, 6'h00);
    rd(8'h22);
    chk("link_pwr reset", rb, 8'h00);
    u_master.half = 7;
    wr(8'h23, 8'hff);
    u_master.half = 4;
    rd(8'h23);
    chk("los readback", rb, 8'h3f);
    chk("los max", {hyst, vth}, 6'h3f);
    wr(8'h23, 8'h0b);
    chk("los codes", {hyst, vth}, 6'b001011);
    dev = 7'h13;
    wr(8'h23, 8'h00);
    chk("foreign addr ack", ack, 1'b0);
    dev = 7'h12;
    rd(8'h23);
    chk("los kept", rb, 8'h0b);
    chk("eq straps", eq, 32'h5555aaaa);
    rd(8'h10);
    chk("up eq read", rb, 8'haa);
    wr(8'h20, 8'h00);
    rd(8'h20);
    chk("dn eq locked", rb, 8'h55);
    wr(8'h0a, 8'h10);
    wr(8'h10, 8'hff);
    wr(8'h11, 8'hff);
    wr(8'h20, 8'hff);
    wr(8'h21, 8'hff);
    chk("eq sw max", eq, 32'hffffffff);
    lin.lfps_present = 1'b1;
    step(2);
    chk("eq lfps zero", eq, 32'h0);
    wr(8'h22, 8'h40);
    chk("eq lfps kept", eq, 32'hffffffff);
    lin.lfps_present = 1'b0;
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 4; c++) begin
        lin.fsm_compliance = f[0];
        wr(8'h22, 8'(c));
        step(2);
        chk("cm flag", lout.compliance_active_flag, c == 1 || c == 2 || (c == 0 && f == 1));
        if (f == 0) chk("cm dirs", {lout.compliance_dfp, lout.compliance_ufp}, {c == 1, c == 2});
      end
    end
    wr(8'h22, 8'h83);
    rd(8'h22);
    chk("cm flag hw", rb, 8'h03);
    wr(8'h22, 8'h00);
    lin = 3'b110;
    cycles_to(1'b0);
    chk("exit fast", n <= 3, 1'b1);
    lin = 3'b000;
    wr(8'h22, 8'h20);
    lin = 3'b110;
    step(10);
    lin.lfps_present = 1'b0;
    step(1);
    lin.lfps_present = 1'b1;
    cycles_to(1'b0);
    chk("exit debounced", n >= DEB && n <= DEB + 3, 1'b1);
    lin = 3'b000;
    for (int c = 0; c < 2; c++) begin
      wr(8'h22, {4'h0, 2'(c), 2'h0});
      cycles_to(1'b1);
      step(1);
      cycles_to(1'b1);
      chk("detect period", n + 1, c == 0 ? SHORT : LONG);
    end
    lin.in_u2u3 = 1'b1;
    cycles_to(1'b1);
    chk("detect in sleep", n <= LONG, 1'b1);
    wr(8'h22, 8'h10);
    cycles_to(1'b1);
    chk("detect off in sleep", n, 200);
    lin.in_u2u3 = 1'b0;
    cycles_to(1'b1);
    chk("detect resumes", n <= LONG, 1'b1);
    astr = 4'hc;
    do_reset();
    dev = 7'h14;
    wr(8'h23, 8'h00);
    chk("strap addr ack", ack, 1'b1);
    mode_strap = 2'h0;
    do_reset();
    chk("pin mode", i2c_mode, 1'b0);
    wr(8'h23, 8'h00);
    chk("pin mode ack", ack, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire

/* File: verification/ulp_i2c_master.sv */
/*
  I2C controller model: drives scl and an open-drain sda, byte by byte.
  Assumes sda_line is the wired-AND of every sda driver with a pull-up.
*/
`default_nettype none
module ulp_i2c_master (
  input  wire logic mclk,
  input  wire logic sda_line,
  output var logic  scl,
  output var logic  sda_drv
);
  timeunit 1ns;
  timeprecision 100ps;
  // Cycles per clock phase; raise it for a slow controller
  int half = 4;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // =====
  // Line timing
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic start();
    sda_drv = 1'b1;
    tick(half);
    scl = 1'b1;
    tick(half);
    sda_drv = 1'b0;
    tick(half);
    scl = 1'b0;
    tick(1);
  endtask
  // Eight data bits MSB first, then the acknowledge clock
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    logic [8:0] b;
    logic [8:0] got;
    b = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      sda_drv = b[i];
      tick(half - 1);
      scl = 1'b1;
      tick(half);
      got[i] = sda_line;
      scl = 1'b0;
      tick(1);
    end
    rx = got[8:1];
    ack = ~got[0];
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    tick(half);
    scl = 1'b1;
    tick(half);
    sda_drv = 1'b1;
    tick(half);
  endtask
endmodule
`default_nettype wire

/* File: verification/ulp_link_ctrl_chk.sv */
/*
  Port checker for ulp_link_ctrl.
  Assumes the bind below attaches it to every instance.
*/
`default_nettype none
module ulp_link_ctrl_chk #(
  parameter int LFPS_DEBOUNCE_CYC = 20,
  parameter int RXDET_SHORT_CYC   = 50,
  parameter int RXDET_LONG_CYC    = 80
) (
  input wire logic                   mclk,
  input wire logic                   srst,
  input wire logic                   scl,
  input wire logic                   sda_out,
  input wire logic                   sda_oe,
  input wire logic                   config_select_hi,
  input wire logic                   config_select_lo,
  input wire ulp_pkg::ulp_link_in_s  link_in,
  input wire ulp_pkg::ulp_link_out_s link_out,
  input wire logic                   i2c_mode,
  input wire logic                   usb_only_mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  logic cond;
  logic fired_reg;
  assign cond = link_in.in_u2u3 && link_in.lfps_present;
  // Marks that the current LFPS episode already produced its exit pulse
  always_ff @(posedge mclk) begin
    if (srst || !cond) fired_reg <= 1'b0;
    else if (link_out.low_power_exit) fired_reg <= 1'b1;
  end
  // =====
  // Properties
  sequence s_one_shot(sig);
    sig ##1 !sig;
  endsequence
  property p_sda_out; !sda_out; endproperty
  property p_sda_edge; $changed(sda_oe) |-> $past(scl, 2) && !$past(scl); endproperty
  property p_gpio_quiet; !i2c_mode |-> !sda_oe; endproperty
  property p_dir_flag;
    (link_out.compliance_dfp || link_out.compliance_ufp) |->
      link_out.compliance_active_flag && !(link_out.compliance_dfp && link_out.compliance_ufp);
  endproperty
  property p_usb_only;
    !$past(srst) && !$past(srst, 2) |-> usb_only_mode == $past(!config_select_hi && config_select_lo);
  endproperty
  property p_exit_cause; link_out.low_power_exit |-> $past(cond); endproperty
  property p_exit_width; link_out.low_power_exit |-> s_one_shot(link_out.low_power_exit); endproperty
  property p_exit_once; link_out.low_power_exit |-> !fired_reg; endproperty
  property p_rxdet_width; link_out.rx_detect_pulse |=> !link_out.rx_detect_pulse [*8]; endproperty
  a_sda_out: assert property (p_sda_out) else $error("sda_out not low");
  a_sda_edge: assert property (p_sda_edge) else $error("sda_oe moved off scl fall");
  a_gpio_quiet: assert property (p_gpio_quiet) else $error("sda driven in pin mode");
  a_dir_flag: assert property (p_dir_flag) else $error("direction without flag");
  a_usb_only: assert property (p_usb_only) else $error("usb_only_mode wrong");
  a_exit_cause: assert property (p_exit_cause) else $error("exit without LFPS in U2/U3");
  a_exit_width: assert property (p_exit_width) else $error("exit pulse too long");
  a_exit_once: assert property (p_exit_once) else $error("second exit in one episode");
  a_rxdet_width: assert property (p_rxdet_width) else $error("detect pulses too close");
endmodule
bind ulp_link_ctrl ulp_link_ctrl_chk #(.LFPS_DEBOUNCE_CYC(LFPS_DEBOUNCE_CYC), .RXDET_SHORT_CYC(RXDET_SHORT_CYC),
  .RXDET_LONG_CYC(RXDET_LONG_CYC)) u_chk (.mclk(mclk), .srst(srst), .scl(scl), .sda_out(sda_out),
  .sda_oe(sda_oe), .config_select_hi(config_select_hi), .config_select_lo(config_select_lo),
  .link_in(link_in), .link_out(link_out), .i2c_mode(i2c_mode), .usb_only_mode(usb_only_mode));
`default_nettype wire
